/* File: rtl/phy_mii_receive_output_port.sv */
// Behaviour
// - nibble receive data synchronous to receive clock
// - serial mode at 10 Mb/s uses lowest data line only
// - enable low floats data, clock, valid, error
// - error high on invalid symbol inside a packet or on the first word after it, 100 Mb/s
// - valid high with data, changes on falling edge
// - valid meaningless in symbol mode
// - twisted-pair path follows forced or negotiated speed
// - fiber driver only in fiber mode, else AUI
// - serial mode at 10 Mb/s gives 10 MHz receive clock
`timescale 1ns/1ps
`default_nettype none
`include "phy_rx_map.svh"

module phy_mii_receive_output_port
  import phy_rx_pkg::*;
#(
  parameter int WORD_W = `RXW_WIDTH,
  parameter int BUF_DEPTH = 2
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // configuration
  input wire logic autoneg_enable,
  input wire logic forced_speed_100,
  input wire logic an_result_100,
  input wire logic fiber_mode_select,
  input wire logic serial_mode,
  input wire logic symbol_mode_n,
  // received words from the decoder
  input wire logic rx_word_valid,
  output logic rx_word_ready,
  input wire logic [3:0] rx_word_data,
  input wire logic rx_word_sym_msb,
  input wire logic rx_word_dv,
  input wire logic rx_word_invalid,
  // receive output enable
  input wire logic rx_enable,
  // receive pins
  output logic [3:0] rxd_o,
  output logic [3:0] rxd_oe_n,
  output logic rx_clk_o,
  output logic rx_clk_oe_n,
  output logic rx_dv_o,
  output logic rx_dv_oe_n,
  output logic rx_er_o,
  output logic rx_er_oe_n,
  // line driver selection
  output logic twisted_pair_transmit_driver_mlt3,
  output logic twisted_pair_receive_buffer_mlt3,
  output logic fiber_transmit_output_en,
  output logic attachment_unit_transmit_output_en,
  // resolved mode, for observation
  output logic speed_100
);

  rx_word_if #(.W(WORD_W)) buf_out (); // buffer to output stage

  logic [WORD_W-1:0] in_word; // packed incoming word
  logic speed_100_r; // resolved speed
  rx_mode_t mode_r; // receive clock mode
  tp_signal_t tp_sig_r; // twisted-pair signaling
  logic fiber_r; // fiber driver active
  logic [4:0] period; // receive clock period in cycles
  logic [4:0] high_len; // cycles receive clock stays high
  logic [4:0] div_cnt_r; // divider position
  logic rx_clk_r; // receive clock level
  logic fall_tick; // receive clock falls at this edge
  logic [3:0] rxd_r; // receive data register
  logic rx_dv_r; // data valid register
  logic rx_er_r; // error register
  logic in_packet_r; // inside a received packet
  logic [WORD_W-1:0] w; // word being launched

  // pack the decoder word into the buffer layout
  assign in_word = {rx_word_invalid, rx_word_dv, rx_word_sym_msb, rx_word_data};

  // two-entry buffer in the data path
  rx_skid_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(rx_word_valid),
    .in_ready(rx_word_ready),
    .in_data(in_word),
    .out(buf_out)
  );

  // words leave only at a falling edge of the receive clock
  assign buf_out.ready = fall_tick;
  assign w = buf_out.data;

  // period lookup for the receive clock
  function automatic logic [4:0] period_of(input rx_mode_t m);
    unique case (m)
      mode_100_nibble: period_of = 5'(`RXCLK_100_PERIOD);
      mode_10_nibble: period_of = 5'(`RXCLK_10_NIBBLE_PERIOD);
      mode_10_serial: period_of = 5'(`RXCLK_10_SERIAL_PERIOD);
      default: period_of = 5'(`RXCLK_100_PERIOD);
    endcase
  endfunction

  // resolve speed and line driver choice from forcing or negotiation
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      speed_100_r <= 1'b0;
      tp_sig_r <= tp_manchester;
      fiber_r <= 1'b0;
    end
    else
    begin
      // fiber operation is always 100 Mb/s
      speed_100_r <= fiber_mode_select ||
                     (autoneg_enable ? an_result_100 : forced_speed_100);
      tp_sig_r <= (autoneg_enable ? an_result_100 : forced_speed_100) ?
                  tp_mlt3 : tp_manchester;
      fiber_r <= fiber_mode_select;
    end
  end

  // receive clock mode follows speed and serial selection
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= mode_10_nibble;
    end
    else if (speed_100_r)
    begin
      mode_r <= mode_100_nibble;
    end
    else if (serial_mode)
    begin
      mode_r <= mode_10_serial;
    end
    else
    begin
      mode_r <= mode_10_nibble;
    end
  end

  assign period = period_of(mode_r);
  assign high_len = period >> 1;
  // the clock drops when the counter reaches the end of its high phase
  assign fall_tick = (div_cnt_r == high_len - 5'd1);

  // receive clock divider; low phase takes the extra cycle of odd periods
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt_r <= '0;
      rx_clk_r <= 1'b1;
    end
    else
    begin
      // wrap, also when a mode change leaves the counter out of range
      if (div_cnt_r >= period - 5'd1)
      begin
        div_cnt_r <= '0;
        rx_clk_r <= 1'b1;
      end
      else
      begin
        div_cnt_r <= div_cnt_r + 5'd1;
        if (fall_tick)
        begin
          rx_clk_r <= 1'b0;
        end
      end
    end
  end

  // packet tracking for error qualification
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      in_packet_r <= 1'b0;
    end
    else if (fall_tick)
    begin
      in_packet_r <= buf_out.valid && w[`RXW_DV_POS];
    end
  end

  // launch data on the falling edge of the receive clock
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rxd_r <= `RX_IDLE_DATA;
    end
    else if (fall_tick)
    begin
      if (!buf_out.valid)
      begin
        // no word ready: hold the lines quiet
        rxd_r <= `RX_IDLE_DATA;
      end
      else if (mode_r == mode_10_serial)
      begin
        // upper lines carry nothing useful, kept at zero
        rxd_r <= {3'h0, w[`RXW_DATA_LSB]};
      end
      else
      begin
        rxd_r <= w[`RXW_DATA_MSB:`RXW_DATA_LSB];
      end
    end
  end

  // data valid launched with the data
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_dv_r <= 1'b0;
    end
    else if (fall_tick)
    begin
      // in symbol mode the flag is still passed but carries no meaning
      rx_dv_r <= buf_out.valid && w[`RXW_DV_POS];
    end
  end

  // receive error, or symbol msb in symbol mode
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_er_r <= 1'b0;
    end
    else if (fall_tick)
    begin
      if (!buf_out.valid)
      begin
        rx_er_r <= 1'b0;
      end
      else if (!symbol_mode_n)
      begin
        rx_er_r <= w[`RXW_SYM_MSB_POS];
      end
      else
      begin
        // only inside a packet or on the first word after it, and only at 100 Mb/s
        rx_er_r <= speed_100_r && w[`RXW_INVALID_POS] &&
                   (w[`RXW_DV_POS] || in_packet_r);
      end
    end
  end

  // pin values
  assign rxd_o = rxd_r;
  assign rx_clk_o = rx_clk_r;
  assign rx_dv_o = rx_dv_r;
  assign rx_er_o = rx_er_r;

  // enable low releases every receive pin
  assign rxd_oe_n = {4{~rx_enable}};
  assign rx_clk_oe_n = ~rx_enable;
  assign rx_dv_oe_n = ~rx_enable;
  assign rx_er_oe_n = ~rx_enable;

  // line driver selection outputs
  assign twisted_pair_transmit_driver_mlt3 = (tp_sig_r == tp_mlt3);
  assign twisted_pair_receive_buffer_mlt3 = (tp_sig_r == tp_mlt3);
  assign fiber_transmit_output_en = fiber_r;
  assign attachment_unit_transmit_output_en = ~fiber_r;
  assign speed_100 = speed_100_r;

endmodule

`default_nettype wire

/* File: rtl/phy_rx_map.svh */
`ifndef PHY_RX_MAP_SVH
`define PHY_RX_MAP_SVH

// system clock rate in kHz
`define SYS_CLK_KHZ 50000
// receive clock rates in kHz: 100 Mb/s nibble, 10 Mb/s nibble, 10 Mb/s serial
`define RXCLK_100_KHZ 25000
`define RXCLK_10_NIBBLE_KHZ 2500
`define RXCLK_10_SERIAL_KHZ 10000
// receive clock periods in system clock cycles
`define RXCLK_100_PERIOD (`SYS_CLK_KHZ / `RXCLK_100_KHZ)
`define RXCLK_10_NIBBLE_PERIOD (`SYS_CLK_KHZ / `RXCLK_10_NIBBLE_KHZ)
`define RXCLK_10_SERIAL_PERIOD (`SYS_CLK_KHZ / `RXCLK_10_SERIAL_KHZ)
// receive word field positions
`define RXW_DATA_LSB 0
`define RXW_DATA_MSB 3
`define RXW_SYM_MSB_POS 4
`define RXW_DV_POS 5
`define RXW_INVALID_POS 6
`define RXW_WIDTH 7
// idle value of the receive outputs
`define RX_IDLE_DATA 4'h0

`endif

/* File: rtl/phy_rx_pkg.sv */
package phy_rx_pkg;

  // receive interface operating mode
  typedef enum logic [1:0]
  {
    mode_100_nibble = 2'b00,
    mode_10_nibble = 2'b01,
    mode_10_serial = 2'b11
  } rx_mode_t;

  // line driver signaling choice for the shared twisted-pair path
  typedef enum logic
  {
    tp_manchester = 1'b0,
    tp_mlt3 = 1'b1
  } tp_signal_t;

endpackage

/* File: rtl/rx_skid_buffer.sv */
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer; a stall at the output loses no word
module rx_skid_buffer
  import phy_rx_pkg::*;
#(
  parameter int W = 7,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  rx_word_if.source out
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH]; // word storage
  logic [PW-1:0] wr_ptr_r; // next slot to fill
  logic [PW-1:0] rd_ptr_r; // next slot to drain
  logic [PW:0] count_r; // words held
  logic push; // word taken in
  logic pop; // word handed out

  // honest full and empty
  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out.valid = (count_r != '0);
  assign out.data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;

  // storage write, no reset needed on data
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      // net change of the fill level
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/rx_word_if.sv */
`timescale 1ns/1ps
`default_nettype none

// valid/ready word carrier between the buffer and the output stage
interface rx_word_if #(parameter int W = 7);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  // side that fills the carrier
  modport source (output valid, output data, input ready);
  // side that drains the carrier
  modport sink (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: tb/mac_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none

// mac side: takes the pins on the rising receive clock
module mac_rx_model (
  // control
  input wire logic clk_sys,
  input wire logic share,
  input wire logic sym_n,
  // resolved receive wires
  input wire logic [3:0] rxd,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  // enable toward the device
  output logic rx_enable
);
  // captured error and data
  logic [4:0] got[$];
  // held high as a node; a sharing repeater drops it
  always @(posedge clk_sys) rx_enable <= !share;
  // dv is ignored in symbol mode, where a nonzero symbol counts
  always @(posedge rx_clk)
    if (sym_n ? rx_dv === 1'b1 : (|{rx_er, rxd}) === 1'b1)
      got.push_back({rx_er, rxd});
endmodule

`default_nettype wire

/* File: tb/mii_rx_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module mii_rx_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // configuration
  input wire logic autoneg_enable,
  input wire logic forced_speed_100,
  input wire logic an_result_100,
  input wire logic fiber_mode_select,
  input wire logic serial_mode,
  input wire logic symbol_mode_n,
  input wire logic rx_enable,
  input wire logic rx_word_ready,
  // receive pins
  input wire logic [3:0] rxd_o,
  input wire logic [3:0] rxd_oe_n,
  input wire logic rx_clk_o,
  input wire logic rx_clk_oe_n,
  input wire logic rx_dv_o,
  input wire logic rx_dv_oe_n,
  input wire logic rx_er_o,
  input wire logic rx_er_oe_n,
  // line drivers and speed
  input wire logic twisted_pair_transmit_driver_mlt3,
  input wire logic twisted_pair_receive_buffer_mlt3,
  input wire logic fiber_transmit_output_en,
  input wire logic attachment_unit_transmit_output_en,
  input wire logic speed_100
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // speed the twisted-pair path should follow
  wire logic tp_want = autoneg_enable ? an_result_100 : forced_speed_100;
  // every receive pin floated
  wire logic off = &{rxd_oe_n, rx_clk_oe_n, rx_dv_oe_n, rx_er_oe_n};

  AST_FLOAT: assert property (!rx_enable |-> off)
    else $error("pins not floated");
  AST_DRIVE: assert property (rx_enable |-> !(|{rxd_oe_n, rx_clk_oe_n, rx_dv_oe_n, rx_er_oe_n}))
    else $error("pins floated while enabled");
  AST_LAUNCH: assert property ($changed({rxd_o, rx_dv_o, rx_er_o}) |-> $fell(rx_clk_o))
    else $error("pins changed off the falling clock");
  AST_SERIAL: assert property ($fell(rx_clk_o) && serial_mode && !speed_100 |-> rxd_o[3:1] == 3'h0)
    else $error("upper lines not quiet in serial");
  AST_ER10: assert property ($fell(rx_clk_o) && !speed_100 && symbol_mode_n |-> !rx_er_o)
    else $error("error raised at 10 Mb/s");
  AST_TP: assert property (1 |=> twisted_pair_transmit_driver_mlt3 == $past(tp_want)
    && twisted_pair_receive_buffer_mlt3 == twisted_pair_transmit_driver_mlt3)
    else $error("twisted pair signaling wrong");
  AST_FX: assert property (1 |=> fiber_transmit_output_en == $past(fiber_mode_select)
    && attachment_unit_transmit_output_en != fiber_transmit_output_en
    && (speed_100 || !fiber_transmit_output_en))
    else $error("fiber driver selection wrong");
  AST_CLK25: assert property (speed_100 && $past(speed_100, 3) |-> rx_clk_o != $past(rx_clk_o))
    else $error("receive clock not 25 MHz");
  AST_CLK2M5: assert property ($rose(rx_clk_o) && !speed_100 && !serial_mode && $past(resetn, 4)
    |-> rx_clk_o[*8] ##1 rx_clk_o[*2] ##1 !rx_clk_o[*8] ##1 !rx_clk_o[*2] ##1 rx_clk_o)
    else $error("receive clock not 2.5 MHz");
  AST_CLK10: assert property ($rose(rx_clk_o) && !speed_100 && serial_mode && $past(resetn, 4)
    |-> rx_clk_o[*2] ##1 !rx_clk_o[*3] ##1 rx_clk_o)
    else $error("receive clock not 10 MHz");

  // main scenarios reached
  cover property ($fell(rx_dv_o));
  cover property (!rx_word_ready);
  cover property ($rose(rx_er_o));
endmodule

bind phy_mii_receive_output_port mii_rx_checker chk_i (.*);

`default_nettype wire

/* File: tb/phy_mii_receive_output_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module phy_mii_receive_output_port_tb;
  import phy_rx_pkg::*;
  // autoneg, forced, result, fiber, serial, sym_n, then speed and tp expected
  typedef struct packed {logic a, f, r, x, s, y, sp, tp;} row_t;
  row_t rows [6] = '{8'h47, 8'ha7, 8'hc4, 8'h2c, 8'h16, 8'h43};
  // words as sym_msb, invalid, nibble
  logic [5:0] wd [3] = '{6'h25, 6'h1a, 6'h2c};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic share = 1'b0;
  logic v = 1'b0;
  // packet flag offered with each word
  logic d = 1'b1;
  // nonzero dv, er, data launched at each receive clock fall
  logic [5:0] seen[$];
  logic [5:0] w = 6'h00;
  row_t c = 8'h47;
  int mismatches = 0;
  int num_checks = 0;
  wire logic rx_enable, rx_word_ready, rx_clk_o, rx_clk_oe_n, rx_dv_o, rx_dv_oe_n;
  wire logic rx_er_o, rx_er_oe_n, tpt, tpr, fxe, aue, speed_100;
  wire logic [3:0] rxd_o, rxd_oe_n;
  // pin levels seen by the mac
  wire logic [3:0] rxd_w = rxd_oe_n == 4'h0 ? rxd_o : 4'hz;
  wire logic rck = rx_clk_oe_n ? 1'bz : rx_clk_o;
  wire logic rdv = rx_dv_oe_n ? 1'bz : rx_dv_o;
  wire logic rer = rx_er_oe_n ? 1'bz : rx_er_o;

  always #10 clk_sys = ~clk_sys;

  phy_mii_receive_output_port uut (.clk_sys(clk_sys), .resetn(resetn),
    .autoneg_enable(c.a), .forced_speed_100(c.f), .an_result_100(c.r),
    .fiber_mode_select(c.x), .serial_mode(c.s), .symbol_mode_n(c.y),
    .rx_word_valid(v), .rx_word_ready(rx_word_ready), .rx_word_data(w[3:0]),
    .rx_word_sym_msb(w[5]), .rx_word_dv(d), .rx_word_invalid(w[4]),
    .rx_enable(rx_enable), .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .rx_clk_o(rx_clk_o),
    .rx_clk_oe_n(rx_clk_oe_n), .rx_dv_o(rx_dv_o), .rx_dv_oe_n(rx_dv_oe_n),
    .rx_er_o(rx_er_o), .rx_er_oe_n(rx_er_oe_n), .twisted_pair_transmit_driver_mlt3(tpt),
    .twisted_pair_receive_buffer_mlt3(tpr), .fiber_transmit_output_en(fxe),
    .attachment_unit_transmit_output_en(aue), .speed_100(speed_100));

  mac_rx_model m (.clk_sys(clk_sys), .share(share), .sym_n(c.y), .rxd(rxd_w),
    .rx_clk(rck), .rx_dv(rdv), .rx_er(rer), .rx_enable(rx_enable));

  // pins read half a system clock after each fall, idle launches skipped
  always @(negedge rx_clk_o)
  begin
    @(negedge clk_sys);
    if ({rx_dv_o, rx_er_o, rxd_o} != 6'h00)
      seen.push_back({rx_dv_o, rx_er_o, rxd_o});
  end

  // compare one result
  task automatic chk(input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // offer a word and hold it until taken
  task automatic send(input logic [5:0] x);
    logic ok;
    v <= 1'b1;
    w <= x;
    do
    begin
      @(negedge clk_sys);
      ok = rx_word_ready;
      @(posedge clk_sys);
    end
    while (ok !== 1'b1);
  endtask

  // word the mac should see in the current mode
  function automatic logic [4:0] exp_w(input logic [5:0] x);
    if (!c.y)
      return {x[5], x[3:0]};
    return {c.sp & x[4], c.s ? {3'h0, x[0]} : x[3:0]};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // six settings, each under a fresh reset, covering 100 Mb/s nibble, 10 Mb/s nibble and 10 Mb/s serial, then the shared-pin case
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      resetn <= 1'b0;
      c <= rows[i];
      repeat (8) @(posedge clk_sys);
      chk(10'h2c0, {rx_clk_o, speed_100, aue, rx_word_ready, rxd_o, rx_dv_o, rx_er_o});
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({c.sp, c.tp, c.tp, c.x, !c.x}, {speed_100, tpt, tpr, fxe, aue});
      m.got.delete();
      for (int k = 0; k < 3; k++)
        send(wd[k]);
      v <= 1'b0;
      repeat (150) @(posedge clk_sys);
      chk(10'h3, 10'(m.got.size()));
      for (int k = 0; k < 3; k++)
        chk(exp_w(wd[k]), m.got[k]);
    end
    share <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(10'h7f, {rxd_oe_n, rx_clk_oe_n, rx_dv_oe_n, rx_er_oe_n});
    m.got.delete();
    send(6'h25);
    v <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk(10'h0, 10'(m.got.size()));
    share <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(10'h0, {rxd_oe_n, rx_clk_oe_n, rx_dv_oe_n, rx_er_oe_n});
    // error marks the first word after a packet, not the ones beyond
    c <= rows[0];
    seen.delete();
    d <= 1'b1;
    send(6'h01);
    d <= 1'b0;
    send(6'h12);
    send(6'h13);
    v <= 1'b0;
    d <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk(10'h3, 10'(seen.size()));
    chk(10'h21, 10'(seen[0]));
    chk(10'h12, 10'(seen[1]));
    chk(10'h03, 10'(seen[2]));
    end_sim;
  end

  // cut a hang short, far past the run of about 1050 cycles
  initial
  begin
    #100000;
    mismatches++;
    end_sim;
  end
endmodule

`default_nettype wire
